// ===== rtl/cpu8_params.svh
// Named constants for the 8-bit core opcode decoder.
// Assumes it is included by bare name from the classifier and decoder modules.
`ifndef CPU8_PARAMS_SVH
`define CPU8_PARAMS_SVH

// ==========================================================================
// Opcode columns (high nibble)
`define COL_BTB        4'h0
`define COL_BSC        4'h1
`define COL_REL        4'h2
`define COL_RMW_DIR    4'h3
`define COL_RMW_ACC    4'h4
`define COL_RMW_IDX    4'h5
`define COL_RMW_IX1    4'h6
`define COL_RMW_IX     4'h7
`define COL_CTL_A      4'h8
`define COL_CTL_B      4'h9
`define COL_IMM        4'hA
`define COL_DIR        4'hB
`define COL_EXT        4'hC
`define COL_IX2        4'hD
`define COL_IX1        4'hE
`define COL_IX         4'hF

// ==========================================================================
// Special opcodes and low-nibble selectors
`define OPC_INDEX_TO_ACC 8'h9F
`define OPC_WAIT         8'h8F
`define OPC_IMM_STORE    8'hA7
`define LO_ZERO_TEST     4'hD
`define LO_LOGIC_FIRST   4'h4

// ==========================================================================
// Instruction lengths in bytes
`define LEN_1          2'h1
`define LEN_2          2'h2
`define LEN_3          2'h3

// ==========================================================================
// Cycle counts
`define CYC_2          4'h2
`define CYC_3          4'h3
`define CYC_4          4'h4
`define CYC_5          4'h5
`define CYC_6          4'h6

// ==========================================================================
// Flag masks, order H I N Z C
`define FLAG_NONE      5'h00
`define FLAG_I         5'h08
`define FLAG_NZ        5'h06
`define FLAG_NZC       5'h07
`define FLAG_C         5'h01

// ==========================================================================
// Misc
`define ZERO_BYTE      8'h00
`define NEED_NONE      2'h0
`define NEED_ONE       2'h1
`define NEED_TWO       2'h2

`endif

// ===== rtl/cpu8_pkg.sv
// Types shared by the opcode decoder modules.
// Assumes cpu8_params.svh is on the include path.
package cpu8_pkg;

  // ========================================================================
  // Enumerations
  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX2, MODE_IX1, MODE_IX,
    MODE_REL, MODE_BTB, MODE_BSC
  } mode_t;

  typedef enum logic [3:0] {
    ALU_SUB, ALU_COMPARE_ACC, ALU_SUBTRACT_WITH_CARRY, ALU_COMPARE_INDEX,
    ALU_AND, ALU_BIT_TEST, ALU_LOAD_ACC, ALU_STORE_ACC, ALU_OTHER
  } alu_t;

  typedef enum logic [0:0] {
    ST_OPCODE, ST_OPERAND
  } state_t;

  // ========================================================================
  // Structures
  typedef struct packed {
    logic [7:0] opcode;
    mode_t      mode;
    alu_t       aluOp;
    logic [1:0] length;
    logic [3:0] cycles;
    logic [4:0] flagMask;
    logic       isZeroTest;
    logic       isIndexToAcc;
    logic       isWait;
    logic       illegal;
  } class_t;

  typedef struct packed {
    class_t      cls;
    logic [15:0] effAddr;
    logic [7:0]  branchOff;
    logic [2:0]  bitNum;
    logic        bitSense;
  } decode_t;

  typedef struct packed {
    state_t      st;
    class_t      cls;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  idx;
    logic [1:0]  need;
    decode_t     dec;
    logic        decValid;
    logic        halted;
  } dec_state_t;

endpackage

// ===== rtl/cpu8_opcode_classify.sv
// Combinational opcode classifier: mode, length, cycles and flag mask.
// Assumes the caller registers whatever it keeps.
`timescale 1ns/1ps
`include "cpu8_params.svh"

module cpu8_opcode_classify (
  // Opcode in
  input  wire logic [7:0]     opcode,
  // Class out
  output cpu8_pkg::class_t    cls
);

  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb begin
    cls              = '0;
    cls.opcode       = opcode;
    cls.aluOp        = cpu8_pkg::ALU_OTHER;
    cls.isZeroTest   = (hi >= `COL_RMW_DIR) && (hi <= `COL_RMW_IX) &&
                       (lo == `LO_ZERO_TEST);
    cls.isIndexToAcc = (opcode == `OPC_INDEX_TO_ACC);
    cls.isWait       = (opcode == `OPC_WAIT);
    cls.illegal      = (opcode == `OPC_IMM_STORE);
    cls.flagMask     = `FLAG_NZC;
    unique case (hi)
      `COL_BTB: begin
        cls.mode = cpu8_pkg::MODE_BTB;
        cls.length = `LEN_3;
        cls.cycles = `CYC_5;
        cls.flagMask = `FLAG_C;
      end
      `COL_BSC: begin
        cls.mode = cpu8_pkg::MODE_BSC;
        cls.length = `LEN_2;
        cls.cycles = `CYC_5;
        cls.flagMask = `FLAG_NONE;
      end
      `COL_REL: begin
        cls.mode = cpu8_pkg::MODE_REL;
        cls.length = `LEN_2;
        cls.cycles = `CYC_3;
        cls.flagMask = `FLAG_NONE;
      end
      `COL_RMW_DIR: begin
        cls.mode = cpu8_pkg::MODE_DIR;
        cls.length = `LEN_2;
        cls.cycles = cls.isZeroTest ? `CYC_4 : `CYC_5;
      end
      `COL_RMW_ACC, `COL_RMW_IDX: begin
        cls.mode = cpu8_pkg::MODE_INH;
        cls.length = `LEN_1;
        cls.cycles = `CYC_3;
      end
      `COL_RMW_IX1: begin
        cls.mode = cpu8_pkg::MODE_IX1;
        cls.length = `LEN_2;
        cls.cycles = cls.isZeroTest ? `CYC_5 : `CYC_6;
      end
      `COL_RMW_IX: begin
        cls.mode = cpu8_pkg::MODE_IX;
        cls.length = `LEN_1;
        cls.cycles = cls.isZeroTest ? `CYC_4 : `CYC_5;
      end
      `COL_CTL_A, `COL_CTL_B: begin
        cls.mode = cpu8_pkg::MODE_INH;
        cls.length = `LEN_1;
        cls.cycles = `CYC_2;
        cls.flagMask = cls.isWait ? `FLAG_I : `FLAG_NONE;
      end
      `COL_IMM: begin
        cls.mode = cpu8_pkg::MODE_IMM;
        cls.length = `LEN_2;
        cls.cycles = `CYC_2;
      end
      `COL_DIR: begin
        cls.mode = cpu8_pkg::MODE_DIR;
        cls.length = `LEN_2;
        cls.cycles = `CYC_3;
      end
      `COL_EXT: begin
        cls.mode = cpu8_pkg::MODE_EXT;
        cls.length = `LEN_3;
        cls.cycles = `CYC_4;
      end
      `COL_IX2: begin
        cls.mode = cpu8_pkg::MODE_IX2;
        cls.length = `LEN_3;
        cls.cycles = `CYC_5;
      end
      `COL_IX1: begin
        cls.mode = cpu8_pkg::MODE_IX1;
        cls.length = `LEN_2;
        cls.cycles = `CYC_4;
      end
      `COL_IX: begin
        cls.mode = cpu8_pkg::MODE_IX;
        cls.length = `LEN_1;
        cls.cycles = `CYC_3;
      end
    endcase
    if (cls.isZeroTest) begin
      cls.flagMask = `FLAG_NZ;
    end
    // Register/memory columns: the low nibble names the operation.
    if (hi >= `COL_IMM) begin
      if (lo < `LO_LOGIC_FIRST) begin
        cls.flagMask = `FLAG_NZC;
      end else begin
        cls.flagMask = `FLAG_NZ;
      end
      if (lo[3] == 1'b0) begin
        cls.aluOp = cpu8_pkg::alu_t'({1'b0, lo[2:0]});
      end
    end
  end

endmodule

// ===== rtl/cpu8_opcode_decode.sv
// Opcode decoder: collects operand bytes and emits one decoded record.
// Assumes a fetch unit on clk_sys presenting bytes with a valid strobe,
// the index register value as a plain input, and a wake request.
`timescale 1ns/1ps
`include "cpu8_params.svh"

module cpu8_opcode_decode (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Instruction byte stream
  input  wire logic              byteValid,
  input  wire logic [7:0]        byteData,
  output logic                   byteReady,
  // Core state
  input  wire logic [7:0]        indexReg,
  input  wire logic              wakeReq,
  // Decoded instruction
  output logic                   decValid,
  output cpu8_pkg::decode_t      decOut,
  output logic                   clearIntMask,
  output logic                   haltClk
);

  // ========================================================================
  // Classification of the incoming opcode
  cpu8_pkg::class_t    clsIn;
  cpu8_pkg::dec_state_t q;
  cpu8_pkg::dec_state_t d;
  logic                 take;

  cpu8_opcode_classify u_classify (
    .opcode (byteData),
    .cls    (clsIn)
  );

  // A halted core must not swallow the byte after the wait opcode.
  assign take = byteValid && byteReady;
  assign byteReady = !q.halted;

  // ========================================================================
  // Effective address and field extraction
  function automatic cpu8_pkg::decode_t build(
      input cpu8_pkg::class_t c, input logic [7:0] b1,
      input logic [7:0] b2, input logic [7:0] x);
    cpu8_pkg::decode_t r;
    r           = '0;
    r.cls       = c;
    r.bitNum    = c.opcode[3:1];
    r.bitSense  = !c.opcode[0];
    unique case (c.mode)
      cpu8_pkg::MODE_DIR, cpu8_pkg::MODE_BSC: begin
        r.effAddr = {`ZERO_BYTE, b1};
      end
      cpu8_pkg::MODE_BTB: begin
        r.effAddr   = {`ZERO_BYTE, b1};
        r.branchOff = b2;
      end
      cpu8_pkg::MODE_REL: begin
        r.branchOff = b1;
      end
      cpu8_pkg::MODE_EXT: begin
        r.effAddr = {b1, b2};
      end
      cpu8_pkg::MODE_IX2: begin
        r.effAddr = 16'({b1, b2} + {`ZERO_BYTE, x});
      end
      cpu8_pkg::MODE_IX1: begin
        r.effAddr = 16'({`ZERO_BYTE, b1} + {`ZERO_BYTE, x});
      end
      cpu8_pkg::MODE_IX: begin
        r.effAddr = {`ZERO_BYTE, x};
      end
      cpu8_pkg::MODE_IMM, cpu8_pkg::MODE_INH: begin
        r.effAddr = '0;
      end
    endcase
    return r;
  endfunction

  // ========================================================================
  // Sequencer
  always_comb begin
    d          = q;
    d.decValid = 1'b0;
    if (q.halted && wakeReq) begin
      d.halted = 1'b0;
    end
    if (take) begin
      unique case (q.st)
        cpu8_pkg::ST_OPCODE: begin
          d.cls  = clsIn;
          d.idx  = indexReg;
          d.b1   = '0;
          d.b2   = '0;
          d.need = 2'(clsIn.length - `LEN_1);
          if (d.need == `NEED_NONE) begin
            d.dec      = build(clsIn, d.b1, d.b2, d.idx);
            d.decValid = 1'b1;
            d.halted   = clsIn.isWait;
          end else begin
            d.st = cpu8_pkg::ST_OPERAND;
          end
        end
        cpu8_pkg::ST_OPERAND: begin
          if (q.need == `NEED_TWO) begin
            d.b1 = byteData;
          end else if (q.cls.length == `LEN_3) begin
            d.b2 = byteData;
          end else begin
            d.b1 = byteData;
          end
          d.need = 2'(q.need - `NEED_ONE);
          if (d.need == `NEED_NONE) begin
            d.dec      = build(q.cls, d.b1, d.b2, q.idx);
            d.decValid = 1'b1;
            d.st       = cpu8_pkg::ST_OPCODE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign decValid     = q.decValid;
  assign decOut       = q.dec;
  assign clearIntMask = q.decValid && q.dec.cls.isWait;
  assign haltClk      = q.halted;

  // ========================================================================
  // Checks
  logic [1:0] byteCnt;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      byteCnt <= '0;
    end else if (take) begin
      byteCnt <= (q.st == cpu8_pkg::ST_OPCODE) ? `LEN_1 : 2'(byteCnt + 2'h1);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  test_flags_a: assert property (decValid && decOut.cls.isZeroTest |->
    decOut.cls.flagMask == `FLAG_NZ &&
    decOut.cls.cycles == ((decOut.cls.mode == cpu8_pkg::MODE_INH) ? `CYC_3 :
    (decOut.cls.mode == cpu8_pkg::MODE_IX1) ? `CYC_5 : `CYC_4))
    else $error("zero test flags or cycles wrong");

  xfer_idx_a: assert property (decValid &&
    decOut.cls.opcode == `OPC_INDEX_TO_ACC |->
    decOut.cls.flagMask == `FLAG_NONE && decOut.cls.cycles == `CYC_2)
    else $error("index transfer decoded wrongly");

  wait_halt_a: assert property (clearIntMask |->
    haltClk && !byteReady && $past(byteData) == `OPC_WAIT)
    else $error("wait did not halt");

  short_offset_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_IX1 |->
    decOut.effAddr == 16'({`ZERO_BYTE, $past(byteData)} +
                          {`ZERO_BYTE, q.idx}))
    else $error("short offset address wrong");

  long_offset_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_IX2 |->
    decOut.effAddr[7:0] == 8'($past(byteData) + q.idx))
    else $error("long offset low byte wrong");

  ext_order_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_EXT |->
    decOut.effAddr[7:0] == $past(byteData) && byteCnt == `LEN_3)
    else $error("extended address order wrong");

  btb_fields_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_BTB |->
    decOut.branchOff == $past(byteData) && decOut.cls.cycles == `CYC_5 &&
    decOut.bitSense == !decOut.cls.opcode[0])
    else $error("bit branch fields wrong");

  plain_index_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_IX |->
    decOut.effAddr == {`ZERO_BYTE, q.idx} && byteCnt == `LEN_1)
    else $error("plain indexed address wrong");

  rel_branch_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_REL |->
    decOut.branchOff == $past(byteData) && byteCnt == `LEN_2)
    else $error("relative branch wrong");

  byte_count_a: assert property (decValid |->
    byteCnt == decOut.cls.length)
    else $error("operand byte count wrong");

  bit_select_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_BSC |->
    decOut.bitNum == decOut.cls.opcode[3:1] && byteCnt == `LEN_2)
    else $error("bit select wrong");

  no_imm_store_a: assert property (decValid &&
    decOut.cls.mode == cpu8_pkg::MODE_IMM |->
    decOut.cls.illegal == (decOut.cls.opcode == `OPC_IMM_STORE))
    else $error("immediate store not flagged");

  rmw_cycles_a: assert property (decValid &&
    decOut.cls.opcode[7:4] == `COL_RMW_ACC |->
    decOut.cls.cycles == `CYC_3 && byteCnt == `LEN_1)
    else $error("accumulator form cycles wrong");

endmodule

// ===== dv/testbench.sv
// Self-checking bench for the opcode decoder, one task per scenario.
// Assumes the decoder package and header are compiled before this file.
`timescale 1ns/1ps

module testbench;

  // ==========================================================================
  // Stimulus and observation
  logic                   clk_sys;
  logic                   sys_rst;
  logic                   byteValid;
  logic [7:0]             byteData;
  logic                   byteReady;
  logic [7:0]             indexReg;
  logic                   wakeReq;
  logic                   decValid;
  cpu8_pkg::decode_t      decOut;
  logic                   clearIntMask;
  logic                   haltClk;
  cpu8_pkg::decode_t      dec;
  logic                   cim;
  int                     num_errors;
  int                     checked;

  cpu8_opcode_decode uut (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .byteValid    (byteValid),
    .byteData     (byteData),
    .byteReady    (byteReady),
    .indexReg     (indexReg),
    .wakeReq      (wakeReq),
    .decValid     (decValid),
    .decOut       (decOut),
    .clearIntMask (clearIntMask),
    .haltClk      (haltClk)
  );

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Sends n bytes back to back, then waits a bounded time for the record.
  // A released byte lane shows the inverse of the last byte, not a copy.
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1,
                       input logic [7:0] b2, input int n,
                       input logic [7:0] x);
    logic [7:0] bs [3];
    logic       got;
    int         lat;
    bs = '{b0, b1, b2};
    got = 1'b0;
    lat = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      byteValid = 1'b1;
      byteData  = bs[i];
      if (i == 0)
        indexReg = x;
    end
    @(negedge clk_sys);
    byteValid = 1'b0;
    byteData  = ~bs[n-1];
    indexReg  = ~x;
    for (int k = 0; k < 4 && !got; k++) begin
      if (decValid === 1'b1) begin
        got = 1'b1;
        lat = k;
        dec = decOut;
        cim = clearIntMask;
      end else
        @(negedge clk_sys);
    end
    chk("decValid", got, 32'h1);
    chk("answer delay", lat, 32'h0);
    chk("opcode echo", dec.cls.opcode, b0);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk("decValid rst", decValid, 32'h0);
    chk("haltClk rst", haltClk, 32'h0);
    chk("clearIntMask rst", clearIntMask, 32'h0);
    chk("byteReady rst", byteReady, 32'h1);
  endtask

  // A reset while halted must release the halt at once.
  task automatic t_mid_reset;
    issue(8'h8F, 8'h00, 8'h00, 1, 8'h00);
    chk("halt before rst", haltClk, 32'h1);
    sys_rst = 1'b1;
    @(negedge clk_sys);
    chk("halt rst", haltClk, 32'h0);
    chk("ready rst", byteReady, 32'h1);
    sys_rst = 1'b0;
    issue(8'hF6, 8'h00, 8'h00, 1, 8'h19);
    chk("rst ix addr", dec.effAddr, 32'h0019);
  endtask

  task automatic t_zero_test;
    logic [7:0] op [5] = '{8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D};
    logic [3:0] cy [5] = '{4'h4, 4'h3, 4'h3, 4'h5, 4'h4};
    int         ln [5] = '{2, 1, 1, 2, 1};
    for (int i = 0; i < 5; i++) begin
      issue(op[i], 8'h21, 8'h00, ln[i], 8'h10);
      chk("zero cycles", dec.cls.cycles, cy[i]);
      chk("zero flags", dec.cls.flagMask, 32'h06);
      chk("zero flag", dec.cls.isZeroTest, 32'h1);
      chk("zero length", dec.cls.length, ln[i]);
    end
  endtask

  task automatic t_index_to_acc;
    issue(8'h9F, 8'h00, 8'h00, 1, 8'h33);
    chk("xfer flag", dec.cls.isIndexToAcc, 32'h1);
    chk("xfer cycles", dec.cls.cycles, 32'h2);
    chk("xfer flags", dec.cls.flagMask, 32'h00);
    chk("xfer length", dec.cls.length, 32'h1);
  endtask

  task automatic t_indexed;
    issue(8'hE6, 8'hFF, 8'h00, 2, 8'h02);
    chk("ix1 addr carry", dec.effAddr, 32'h0101);
    chk("ix1 mode", dec.cls.mode, cpu8_pkg::MODE_IX1);
    issue(8'h66, 8'h10, 8'h00, 2, 8'h20);
    chk("ix1 rmw addr", dec.effAddr, 32'h0030);
    issue(8'hD6, 8'h12, 8'h34, 3, 8'h05);
    chk("ix2 addr", dec.effAddr, 32'h1239);
    chk("ix2 length", dec.cls.length, 32'h3);
    issue(8'hF6, 8'h00, 8'h00, 1, 8'h7A);
    chk("ix addr", dec.effAddr, 32'h007A);
    chk("ix length", dec.cls.length, 32'h1);
    issue(8'h77, 8'h00, 8'h00, 1, 8'hC3);
    chk("ix rmw addr", dec.effAddr, 32'h00C3);
  endtask

  task automatic t_extended;
    issue(8'hC6, 8'hAB, 8'hCD, 3, 8'h44);
    chk("ext addr", dec.effAddr, 32'hABCD);
    chk("ext length", dec.cls.length, 32'h3);
    chk("ext mode", dec.cls.mode, cpu8_pkg::MODE_EXT);
  endtask

  task automatic t_bit_ops;
    issue(8'h03, 8'h40, 8'hF0, 3, 8'h00);
    chk("btb addr", dec.effAddr, 32'h0040);
    chk("btb offset", dec.branchOff, 32'hF0);
    chk("btb bit", dec.bitNum, 32'h1);
    chk("btb sense", dec.bitSense, 32'h0);
    chk("btb cycles", dec.cls.cycles, 32'h5);
    issue(8'h0E, 8'h12, 8'h05, 3, 8'h00);
    chk("btb set bit", dec.bitNum, 32'h7);
    chk("btb set sense", dec.bitSense, 32'h1);
    issue(8'h1C, 8'h55, 8'h00, 2, 8'h00);
    chk("bsc addr", dec.effAddr, 32'h0055);
    chk("bsc bit", dec.bitNum, 32'h6);
    chk("bsc sense", dec.bitSense, 32'h1);
    chk("bsc cycles", dec.cls.cycles, 32'h5);
    issue(8'h11, 8'h56, 8'h00, 2, 8'h00);
    chk("bsc clr bit", dec.bitNum, 32'h0);
    chk("bsc clr sense", dec.bitSense, 32'h0);
  endtask

  task automatic t_branch;
    issue(8'h27, 8'h80, 8'h00, 2, 8'h00);
    chk("rel offset", dec.branchOff, 32'h80);
    chk("rel length", dec.cls.length, 32'h2);
    chk("rel cycles", dec.cls.cycles, 32'h3);
  endtask

  task automatic t_reg_mem;
    for (int i = 0; i < 8; i++) begin
      issue({4'hB, i[3:0]}, 8'h09, 8'h00, 2, 8'h00);
      chk("alu op", dec.cls.aluOp, cpu8_pkg::alu_t'(i));
      chk("alu legal", dec.cls.illegal, 32'h0);
    end
    issue(8'hA7, 8'h01, 8'h00, 2, 8'h00);
    chk("imm store", dec.cls.illegal, 32'h1);
  endtask

  task automatic t_rmw;
    issue(8'h30, 8'h08, 8'h00, 2, 8'h00);
    chk("rmw dir cycles", dec.cls.cycles, 32'h5);
    issue(8'h40, 8'h00, 8'h00, 1, 8'h00);
    chk("rmw acc cycles", dec.cls.cycles, 32'h3);
    chk("rmw acc length", dec.cls.length, 32'h1);
    issue(8'h50, 8'h00, 8'h00, 1, 8'h00);
    chk("rmw idx cycles", dec.cls.cycles, 32'h3);
  endtask

  // Bytes offered while halted must stay untaken until the wake request.
  task automatic t_wait;
    issue(8'h8F, 8'h00, 8'h00, 1, 8'h00);
    chk("wait mask pulse", cim, 32'h1);
    chk("wait flag", dec.cls.isWait, 32'h1);
    chk("wait cycles", dec.cls.cycles, 32'h2);
    chk("wait flags", dec.cls.flagMask, 32'h08);
    chk("halt level", haltClk, 32'h1);
    @(negedge clk_sys);
    byteValid = 1'b1;
    byteData  = 8'h9F;
    repeat (3) begin
      chk("halt ready", byteReady, 32'h0);
      chk("halt no decode", decValid, 32'h0);
      chk("mask pulse ends", clearIntMask, 32'h0);
      chk("halt stays", haltClk, 32'h1);
      @(negedge clk_sys);
    end
    byteValid = 1'b0;
    byteData  = 8'h60;
    wakeReq   = 1'b1;
    @(negedge clk_sys);
    wakeReq   = 1'b0;
    chk("wake halt", haltClk, 32'h0);
    chk("wake ready", byteReady, 32'h1);
    issue(8'h9F, 8'h00, 8'h00, 1, 8'h5A);
    chk("after wake", dec.cls.isIndexToAcc, 32'h1);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    sys_rst    = 1'b1;
    byteValid  = 1'b0;
    byteData   = 8'h00;
    indexReg   = 8'h00;
    wakeReq    = 1'b0;
    num_errors = 0;
    checked    = 0;
    repeat (20) @(negedge clk_sys);
    t_reset();
    sys_rst = 1'b0;
    t_zero_test();
    t_index_to_acc();
    t_indexed();
    t_extended();
    t_bit_ops();
    t_branch();
    t_reg_mem();
    t_rmw();
    t_wait();
    t_mid_reset();
    wrap_up();
  end

  // The whole run takes about 120 cycles; this leaves ample margin.
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end

endmodule
